// ### anadv_pkg.sv
package anadv_pkg;

  // Management addressing of the advertisement words.
  localparam logic [4:0]  ANADV_DEVAD       = 5'h07;
  localparam logic [15:0] ANADV_MIDDLE_ADDR = 16'h0203;
  localparam logic [15:0] ANADV_UPPER_ADDR  = 16'h0204;

  // Reset values; strap-dependent bits are merged in during reset.
  localparam logic [15:0] ANADV_MIDDLE_RESET = 16'h4000;
  localparam logic [15:0] ANADV_UPPER_RESET  = 16'h0000;

  // Field positions.
  localparam int ANADV_LONG_REACH_BIT = 14;
  localparam int ANADV_ROLE_BIT       = 4;
  localparam int ANADV_HI_CAPABLE_BIT = 13;
  localparam int ANADV_HI_REQUEST_BIT = 12;

  // Writable bits; every other position is reserved.
  localparam logic [15:0] ANADV_MIDDLE_WMASK = 16'h4010;
  localparam logic [15:0] ANADV_UPPER_WMASK  = 16'h3000;

  // Base page bit 20 is bit 4 of the nonce field.
  localparam int ANADV_PAGE_ROLE_BIT = 20;

  typedef struct packed {
    logic [4:0]  devad;
    logic [15:0] regaddr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } anadv_req_type;

  typedef struct packed {
    logic leader;
    logic hi_capable;
    logic hi_request;
  } anadv_strap_type;

  typedef struct packed {
    logic valid;
    logic hi_capable;
    logic hi_request;
  } anadv_partner_type;

endpackage : anadv_pkg

// ### anadv_regs.sv
`timescale 1ns/1ps

module anadv_regs (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // Management register access
  input  wire anadv_pkg::anadv_req_type    mgmt_req_i,
  output logic [15:0]                      mgmt_rdata_o,
  output logic                             mgmt_rvalid_o,
  // Configuration straps and lower word force bit
  input  wire anadv_pkg::anadv_strap_type  strap_i,
  input  wire logic                        adv_role_forced_i,
  // Link partner advertisement
  input  wire anadv_pkg::anadv_partner_type partner_i,
  // Advertised state toward the autonegotiation engine
  output logic [15:0]                      middle_word_o,
  output logic [15:0]                      upper_word_o,
  output logic [47:16]                     tx_page_o,
  output logic                             role_leader_o,
  output logic                             role_forced_o,
  output logic                             tx_high_amplitude_o
);
  import anadv_pkg::*;

  logic [15:0] autoneg_advert_middle_word;
  logic [15:0] autoneg_advert_upper_word;
  logic [15:0] next_middle;
  logic [15:0] next_upper;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_high_amp;
  logic        hit_dev;
  logic        hit_middle;
  logic        hit_upper;
  logic        adv_long_reach_ability;
  logic        adv_role_leader;
  logic        adv_high_amplitude_capable;
  logic        adv_high_amplitude_request;

  assign hit_dev    = (mgmt_req_i.devad == ANADV_DEVAD);
  assign hit_middle = hit_dev && (mgmt_req_i.regaddr == ANADV_MIDDLE_ADDR);
  assign hit_upper  = hit_dev && (mgmt_req_i.regaddr == ANADV_UPPER_ADDR);

  assign adv_long_reach_ability     =
    autoneg_advert_middle_word[ANADV_LONG_REACH_BIT];
  assign adv_role_leader            =
    autoneg_advert_middle_word[ANADV_ROLE_BIT];
  assign adv_high_amplitude_capable =
    autoneg_advert_upper_word[ANADV_HI_CAPABLE_BIT];
  assign adv_high_amplitude_request =
    autoneg_advert_upper_word[ANADV_HI_REQUEST_BIT];

  // Register write path.
  always_comb begin
    next_middle = autoneg_advert_middle_word;
    next_upper  = autoneg_advert_upper_word;
    if (mgmt_req_i.wr && hit_middle) begin
      next_middle = mgmt_req_i.wdata & ANADV_MIDDLE_WMASK;
    end
    if (mgmt_req_i.wr && hit_upper) begin
      next_upper = mgmt_req_i.wdata & ANADV_UPPER_WMASK;
    end
    if (!reset_n_i) begin
      // Straps load on every reset cycle; the level at release sticks.
      next_middle = ANADV_MIDDLE_RESET;
      next_middle[ANADV_ROLE_BIT] = strap_i.leader;
      next_upper  = ANADV_UPPER_RESET;
      next_upper[ANADV_HI_CAPABLE_BIT] = strap_i.hi_capable;
      next_upper[ANADV_HI_REQUEST_BIT] = strap_i.hi_request;
    end
  end

  always_ff @(posedge clk_i) begin
    autoneg_advert_middle_word <= next_middle;
    autoneg_advert_upper_word  <= next_upper;
  end

  // Read path; unmapped addresses answer zero so software sees no stale data.
  always_comb begin
    next_rdata  = 16'h0000;
    next_rvalid = 1'b0;
    if (reset_n_i && mgmt_req_i.rd) begin
      next_rvalid = 1'b1;
      if (hit_middle) begin
        next_rdata = autoneg_advert_middle_word;
      end else if (hit_upper) begin
        next_rdata = autoneg_advert_upper_word;
      end
    end
  end

  // Amplitude resolution; low level until the partner page is valid, since
  // a stale partner ability must never push the line to the high level.
  always_comb begin
    next_high_amp = 1'b0;
    if (partner_i.valid && adv_long_reach_ability &&
        adv_high_amplitude_capable && partner_i.hi_capable) begin
      next_high_amp = adv_high_amplitude_request ||
                      partner_i.hi_request;
    end
    if (!reset_n_i) begin
      next_high_amp = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    mgmt_rdata_o        <= next_rdata;
    mgmt_rvalid_o       <= next_rvalid;
    tx_high_amplitude_o <= next_high_amp;
    middle_word_o       <= next_middle;
    upper_word_o        <= next_upper;
    tx_page_o           <= {next_upper, next_middle};
    role_leader_o       <= next_middle[ANADV_ROLE_BIT];
    role_forced_o       <= reset_n_i && adv_role_forced_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence wr_middle_s;
    mgmt_req_i.wr && hit_middle;
  endsequence

  sequence wr_upper_s;
    mgmt_req_i.wr && hit_upper;
  endsequence

  middle_write_a: assert property (
    wr_middle_s |=> autoneg_advert_middle_word ==
                    ($past(mgmt_req_i.wdata) & ANADV_MIDDLE_WMASK))
    else $error("Middle word did not take the written value.");

  upper_write_a: assert property (
    wr_upper_s |=> autoneg_advert_upper_word ==
                   ($past(mgmt_req_i.wdata) & ANADV_UPPER_WMASK))
    else $error("Upper word did not take the written value.");

  reserved_zero_a: assert property (
    ((autoneg_advert_middle_word & ~ANADV_MIDDLE_WMASK) == 16'h0000) &&
    ((autoneg_advert_upper_word & ~ANADV_UPPER_WMASK) == 16'h0000))
    else $error("A reserved bit is set.");

  reset_value_a: assert property (
    $past(!reset_n_i) |-> adv_long_reach_ability &&
      adv_role_leader == $past(strap_i.leader) &&
      adv_high_amplitude_capable == $past(strap_i.hi_capable))
    else $error("Reset value or strap capture is wrong.");

  read_middle_a: assert property (
    mgmt_req_i.rd && hit_middle |=>
      mgmt_rvalid_o && mgmt_rdata_o == $past(autoneg_advert_middle_word))
    else $error("Middle word read returned wrong data.");

  read_unmapped_a: assert property (
    mgmt_req_i.rd && !hit_middle && !hit_upper |=>
      mgmt_rvalid_o && mgmt_rdata_o == 16'h0000)
    else $error("Unmapped read did not return zero.");

  low_amplitude_a: assert property (
    !partner_i.hi_capable || !adv_high_amplitude_capable |=>
      !tx_high_amplitude_o)
    else $error("High amplitude chosen without ability on both sides.");

  high_amplitude_a: assert property (
    partner_i.valid && adv_long_reach_ability && partner_i.hi_capable &&
    adv_high_amplitude_capable &&
    (partner_i.hi_request || adv_high_amplitude_request) |=>
      tx_high_amplitude_o)
    else $error("High amplitude not chosen when both capable and requested.");

  nonce_role_a: assert property (
    tx_page_o[ANADV_PAGE_ROLE_BIT] == adv_role_leader)
    else $error("Nonce bit 4 does not carry the role.");

  role_forced_a: assert property (
    adv_role_forced_i |=> role_forced_o)
    else $error("Forced role flag not reflected.");

  sequence rd_upper_s;
    mgmt_req_i.rd && hit_upper;
  endsequence

  read_upper_a: assert property (
    rd_upper_s |=>
      mgmt_rvalid_o && mgmt_rdata_o == $past(autoneg_advert_upper_word))
    else $error("Upper word read returned wrong data.");

  // Read data falls back to zero so a stale word is never taken as an answer.
  read_idle_a: assert property (
    !mgmt_req_i.rd |=> !mgmt_rvalid_o && mgmt_rdata_o == 16'h0000)
    else $error("Read answer stood longer than one cycle.");

  reset_upper_a: assert property (
    $past(!reset_n_i) |->
      adv_high_amplitude_request == $past(strap_i.hi_request) &&
      (autoneg_advert_upper_word & ~ANADV_UPPER_WMASK) == ANADV_UPPER_RESET)
    else $error("Upper word reset value or request strap is wrong.");

  page_words_a: assert property (
    tx_page_o == {upper_word_o, middle_word_o} &&
    middle_word_o == autoneg_advert_middle_word &&
    upper_word_o == autoneg_advert_upper_word)
    else $error("Word outputs or page do not match the registers.");

  role_output_a: assert property (
    role_leader_o == adv_role_leader)
    else $error("Role output does not follow the role bit.");

  role_preferred_a: assert property (
    !adv_role_forced_i |=> !role_forced_o)
    else $error("Preferred role reported as forced.");

  amp_needs_page_a: assert property (
    !partner_i.valid || !adv_long_reach_ability |=> !tx_high_amplitude_o)
    else $error("High amplitude chosen without a valid long-reach page.");

endmodule : anadv_regs

// ### anadv_partner.sv
`timescale 1ns/1ps

// Far-end PHY model. It shows its level ability one clock after the bench
// sets it, the same delay a received base page would have.
module anadv_partner
  import anadv_pkg::*;
(
  // Clock
  input  wire logic                         clk_i,
  // Commanded ability: bit 1 capable, bit 0 request
  input  wire logic [1:0]                   abil_i,
  output anadv_pkg::anadv_partner_type      partner_o
);
  always_ff @(posedge clk_i) begin
    partner_o.valid      <= 1'b1;
    partner_o.hi_capable <= abil_i[1];
    partner_o.hi_request <= abil_i[0];
  end
endmodule : anadv_partner

// ### anadv_regs_tb.sv
`timescale 1ns/1ps

module anadv_regs_tb;
  import anadv_pkg::*;
  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  anadv_req_type     mgmt_req_i = '0;
  anadv_strap_type   strap_i = 3'b110;
  logic              adv_role_forced_i = 1'b0;
  logic [1:0]        abil = 2'b00;
  anadv_partner_type partner_i;
  logic [15:0]       mgmt_rdata_o, middle_word_o, upper_word_o;
  logic [47:16]      tx_page_o;
  logic              mgmt_rvalid_o, role_leader_o, role_forced_o;
  logic              tx_high_amplitude_o;
  int                err_total = 0;
  int                n_checks = 0;
  int                cyc = 0;

  anadv_regs dut_u (.clk_i, .reset_n_i, .mgmt_req_i, .mgmt_rdata_o,
    .mgmt_rvalid_o, .strap_i, .adv_role_forced_i, .partner_i,
    .middle_word_o, .upper_word_o, .tx_page_o, .role_leader_o,
    .role_forced_o, .tx_high_amplitude_o);
  anadv_partner far_u (.clk_i(clk_i), .abil_i(abil), .partner_o(partner_i));

  always #50 clk_i = ~clk_i;

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i) mgmt_req_i <= '{ANADV_DEVAD, a, 1'b1, 1'b0, d};
    @(posedge clk_i) mgmt_req_i <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] dv, input logic [15:0] a,
                    input logic [15:0] exp);
    @(posedge clk_i) mgmt_req_i <= '{dv, a, 1'b0, 1'b1, 16'h0000};
    @(posedge clk_i) mgmt_req_i <= '0;
    #1 chk({15'h0000, mgmt_rvalid_o}, 16'h0001);
    chk(mgmt_rdata_o, exp);
  endtask : rd

  task automatic t_reset;
    chk(middle_word_o, 16'h4010);
    chk(upper_word_o, 16'h2000);
    rd(ANADV_DEVAD, ANADV_MIDDLE_ADDR, 16'h4010);
    rd(ANADV_DEVAD, ANADV_UPPER_ADDR, 16'h2000);
  endtask : t_reset

  task automatic t_fields;
    wr(ANADV_MIDDLE_ADDR, 16'hffff);
    rd(ANADV_DEVAD, ANADV_MIDDLE_ADDR, 16'h4010);
    wr(ANADV_MIDDLE_ADDR, 16'h0000);
    chk({15'h0000, tx_page_o[ANADV_PAGE_ROLE_BIT]}, 16'h0000);
    chk({15'h0000, role_leader_o}, 16'h0000);
    rd(ANADV_DEVAD, ANADV_MIDDLE_ADDR, 16'h0000);
    wr(ANADV_UPPER_ADDR, 16'hffff);
    rd(ANADV_DEVAD, ANADV_UPPER_ADDR, 16'h3000);
    rd(ANADV_DEVAD, 16'h0205, 16'h0000);
    rd(5'h01, ANADV_MIDDLE_ADDR, 16'h0000);
    wr(ANADV_MIDDLE_ADDR, 16'h4010);
    chk(tx_page_o[47:32], 16'h3000);
    chk(tx_page_o[31:16], 16'h4010);
    chk({15'h0000, tx_page_o[ANADV_PAGE_ROLE_BIT]}, 16'h0001);
    chk({15'h0000, role_leader_o}, 16'h0001);
  endtask : t_fields

  // Every mix of local and far-end ability and request.
  task automatic t_level;
    for (int i = 0; i < 16; i++) begin
      wr(ANADV_UPPER_ADDR, {2'b00, i[3:2], 12'h000});
      @(posedge clk_i) abil <= i[1:0];
      repeat (3) @(posedge clk_i);
      #1 chk({15'h0000, tx_high_amplitude_o},
             {15'h0000, i[3] & i[1] & (i[2] | i[0])});
    end
  endtask : t_level

  task automatic t_role;
    @(posedge clk_i) adv_role_forced_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({15'h0000, role_forced_o}, 16'h0001);
    @(posedge clk_i) adv_role_forced_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({15'h0000, role_forced_o}, 16'h0000);
  endtask : t_role

  // Second reset with other straps; the level at release must stick.
  task automatic t_strap;
    @(posedge clk_i) begin
      reset_n_i <= 1'b0;
      strap_i   <= 3'b001;
    end
    @(posedge clk_i);
    #1 chk({15'h0000, tx_high_amplitude_o}, 16'h0000);
    @(posedge clk_i) reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(middle_word_o, 16'h4000);
    chk(upper_word_o, 16'h1000);
    rd(ANADV_DEVAD, ANADV_UPPER_ADDR, 16'h1000);
    wr(ANADV_UPPER_ADDR, 16'h2000);
    @(posedge clk_i);
    #1 chk({15'h0000, tx_high_amplitude_o}, 16'h0001);
  endtask : t_strap

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    t_reset();
    t_fields();
    t_level();
    t_role();
    t_strap();
    stop_test();
  end
endmodule : anadv_regs_tb
